// *** dv/mrs_master_model.sv ***
// Master model for the serial slave: sends requests, gathers answers.
// Assumes the bench resolves the shared line (pulled up) and feeds it back.
`timescale 1ns/1ps
module mrs_master_model (
  input wire logic sys_clk,
  input wire logic lineIn,
  input wire logic txOe,
  output logic lineOut,
  output logic lineOe
);
  // Released at start, so the pull-up decides the idle level
  initial begin
    lineOut = 1'b1;
    lineOe = 1'b0;
  end

  // Whole frame, LSB first, one stop bit, binary bytes
  task automatic send(input logic [7:0] q[$], input int per);
    logic [9:0] ch;
    @(negedge sys_clk);
    lineOe = 1'b1;
    foreach (q[i]) begin
      ch = {1'b1, q[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        lineOut = ch[b];
        repeat (per) @(negedge sys_clk);
      end
    end
    // Release only after the full stop bit
    lineOe = 1'b0;
  endtask

  // Samples at mid-bit while the slave drives; empty if it stays silent
  task automatic recv(output logic [7:0] q[$], input int per);
    logic [7:0] ch;
    int n;
    q = {};
    n = 0;
    while (txOe !== 1'b1 && n < 200 * per) begin
      @(negedge sys_clk);
      n++;
    end
    while (txOe === 1'b1) begin
      @(negedge sys_clk);
      if (lineIn === 1'b0) begin
        repeat (per / 2) @(negedge sys_clk);
        for (int b = 0; b < 8; b++) begin
          repeat (per) @(negedge sys_clk);
          ch[b] = lineIn;
        end
        repeat (per) @(negedge sys_clk);
        q.push_back(ch);
      end
    end
  endtask
endmodule // mrs_master_model

// *** dv/test_modbus_rtu_slave_commands.sv ***
// Self-checking bench for the serial command slave at a reduced clock rate.
// Assumes the master model above and a pulled-up shared line.
`timescale 1ns/1ps
module test_modbus_rtu_slave_commands;
  import mrs_pkg::*;
  localparam int CLK = 240_000; // Short bit periods
  logic sysClk, resetn, mOut, mOe, txd, txOe, wrStrobe, lineLvl;
  logic [1:0] rateSel;
  logic [15:0] wrAddr, wrData;
  int failures, tests_run, per;
  int rates[4] = '{BAUD_2400, BAUD_4800, BAUD_9600, BAUD_19200};
  logic [15:0] wA[$], wD[$]; // Writes seen
  logic [15:0] mem[logic [7:0]]; // Expected table

  // Slave wins when enabled, else master, else pull-up
  assign lineLvl = txOe ? txd : (mOe ? mOut : 1'b1);

  mrs_slave #(.CLK_HZ(CLK), .SLAVE_ID(8'h01), .AW(8)) uut (
    .sys_clk(sysClk), .resetn(resetn), .rxd(lineLvl),
    .serialBitRateSetting(rateSel), .txd(txd), .txOe(txOe),
    .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData));

  mrs_master_model mst (.sys_clk(sysClk), .lineIn(lineLvl), .txOe(txOe),
    .lineOut(mOut), .lineOe(mOe));

  initial begin
    sysClk = 1'b0;
    forever #2 sysClk = ~sysClk;
  end

  // Log word writes; flag two drivers at once
  always @(posedge sysClk) begin
    if (wrStrobe === 1'b1) begin
      wA.push_back(wrAddr);
      wD.push_back(wrData);
    end
    if (txOe === 1'b1 && mOe === 1'b1) begin
      failures++;
      $display("wrong value line drivers expected 1 seen 2");
    end
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reflected CRC, computed here on its own
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic seal(inout logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask

  // One request and its answer, compared byte by byte
  task automatic xfer(input logic [7:0] r[$], input logic [7:0] e[$]);
    logic [7:0] g[$];
    seal(r);
    seal(e);
    wA = {};
    wD = {};
    mst.send(r, per);
    mst.recv(g, per);
    check("answer length", e.size(), g.size());
    foreach (e[i]) check("answer byte", e[i], g[i]);
    repeat (4 * per) @(negedge sysClk);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  initial begin
    repeat (95000) @(posedge sysClk);
    failures++;
    tally_and_finish;
  end

  initial begin
    logic [15:0] a, d;
    logic [7:0] q[$], e[$];
    resetn = 1'b0;
    rateSel = 2'h3;
    void'($urandom(68630));
    repeat (20) @(posedge sysClk);
    @(negedge sysClk);
    resetn = 1'b1;
    check("txOe idle", 1'b0, txOe);
    check("txd idle", 1'b1, txd);
    // Echo at every rate; the period follows the setting
    for (int s = 0; s < 4; s++) begin
      rateSel = 2'(s);
      per = CLK / rates[s];
      d = 16'($urandom);
      q = {8'h01, FN_DIAG, 8'h00, 8'h00, d[15:8], d[7:0]};
      xfer(q, q);
      $display("rate %0d echo done", s);
    end
    // Single word write, echoed and strobed once
    a = 16'($urandom);
    d = 16'($urandom);
    q = {8'h01, FN_WRITE1, a[15:8], a[7:0], d[15:8], d[7:0]};
    xfer(q, q);
    check("write count", 1, wA.size());
    check("write addr", a, wA[0]);
    check("write data", d, wD[0]);
    $display("single write done");
    // Sixteen words, the largest count
    a[3:0] = 4'h0;
    q = {8'h01, FN_WRITEN, a[15:8], a[7:0], 8'h00, 8'h10, 8'h20};
    for (int k = 0; k < 16; k++) begin
      d = 16'($urandom);
      mem[{a[11:8], 4'(k)}] = d;
      q.push_back(d[15:8]);
      q.push_back(d[7:0]);
    end
    xfer(q, {8'h01, FN_WRITEN, a[15:8], a[7:0], 8'h00, 8'h10});
    check("multi count", 16, wA.size());
    foreach (wA[k]) check("multi addr", a + 16'(k), wA[k]);
    foreach (wD[k]) check("multi data", mem[{a[11:8], 4'(k)}], wD[k]);
    $display("multi write done");
    // Read them back as one ascending run
    e = {8'h01, FN_READ, 8'h20};
    for (int k = 0; k < 16; k++) begin
      d = mem[{a[11:8], 4'(k)}];
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    xfer({8'h01, FN_READ, a[15:8], a[7:0], 8'h00, 8'h10}, e);
    $display("read back done");
    // Refusals: none of them may write
    xfer({8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h01, 8'h85, EXC_FUNC});
    check("no write bad code", 0, wA.size());
    xfer({8'h01, FN_DIAG, 8'h00, 8'h01, 8'h12, 8'h34}, {8'h01, 8'h88, EXC_FUNC});
    xfer({8'h01, FN_READ, a[15:8], a[7:0], 8'h00, 8'h00}, {8'h01, 8'h83, EXC_VALUE});
    q = {8'h01, FN_WRITEN, a[15:8], a[7:0], 8'h00, 8'h11, 8'h22};
    for (int k = 0; k < 34; k++) q.push_back(8'($urandom));
    xfer(q, {8'h01, 8'h90, EXC_VALUE});
    check("no write count 17", 0, wA.size());
    $display("refusals done");
    // Broadcast write: stored, never answered
    wA = {};
    wD = {};
    a = 16'($urandom);
    d = 16'($urandom);
    q = {8'h00, FN_WRITE1, a[15:8], a[7:0], d[15:8], d[7:0]};
    seal(q);
    mst.send(q, per);
    mst.recv(e, per);
    check("broadcast answer", 0, e.size());
    check("broadcast count", 1, wA.size());
    check("broadcast addr", a, wA[0]);
    check("broadcast data", d, wD[0]);
    // Corrupted checksum: dropped silently, nothing written
    wA = {};
    q = {8'h01, FN_WRITE1, a[15:8], a[7:0], d[15:8], d[7:0]};
    seal(q);
    q[7] = ~q[7];
    mst.send(q, per);
    mst.recv(e, per);
    check("bad crc answer", 0, e.size());
    check("bad crc write", 0, wA.size());
    $display("broadcast and bad crc done");
    tally_and_finish;
  end
endmodule // test_modbus_rtu_slave_commands

// *** include/mrs_pkg.sv ***
// Shared constants for the serial command slave: rates, codes, lengths.
// Assumes 8N1 characters on a half-duplex line and a 16-bit parameter table.
package mrs_pkg;
  // Divider width, large enough for the slowest rate at the default clock
  localparam int DIV_W = 17;
  // Selectable line rates in bits per second
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  // Frame ends after 3.5 idle characters of 10 bits
  localparam logic [5:0] GAP_BITS = 6'h23;
  localparam logic [15:0] MAX_WORDS = 16'h0010;
  // Command codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  // Exception answer fields
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  // Reflected CRC-16 of the protocol
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  // Request lengths in bytes, CRC included
  localparam logic [5:0] LEN_FIXED = 6'h08;
  localparam logic [5:0] LEN_MULTI_BASE = 6'h09;
  localparam logic [5:0] LEN_MAX = 6'h3f;
  localparam logic [5:0] DATA_START = 6'h07;
  // Answer lengths in bytes, CRC included
  localparam logic [6:0] TX_LEN_FIXED = 7'h08;
  localparam logic [6:0] TX_LEN_EXC = 7'h05;
  localparam logic [6:0] TX_LEN_READ_BASE = 7'h05;
  localparam logic [6:0] RD_DATA_START = 7'h03;
  // Bit slot of the stop bit within a character
  localparam logic [3:0] STOP_BIT = 4'h9;
  // Frame handling states, Gray along idle-check-commit-answer
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_CHECK = 2'b01,
    S_COMMIT = 2'b11,
    S_TX = 2'b10
  } mrs_state_t;
endpackage

// *** verilog/mrs_param_mem.sv ***
// Parameter word table: one write port, one registered read port.
// Assumes writer and reader share sys_clk; contents are not reset.
`timescale 1ns/1ps
module mrs_param_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [DW-1:0] wData,
  input wire logic [AW-1:0] rAddr,
  output logic [DW-1:0] rData
);
  // Storage, left unreset so it maps onto block RAM
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rData <= '0;
    end else begin
      rData <= mem[rAddr];
    end
  end
endmodule // mrs_param_mem

// *** verilog/mrs_slave.sv ***
// Serial command slave: frames requests, checks them, writes words, answers.
// Assumes rxd is an asynchronous line pin and the rate select is static logic.
`timescale 1ns/1ps
// Contract
// R1 - One driver at a time, release before answer
// R2 - Read returns count consecutive words, max sixteen
// R3 - Master reads only contiguous ascending address runs
// R4 - Items are 16-bit words as binary byte pairs
// R5 - Single write updates exactly one word
// R6 - Bit period follows selected rate setting
// R7 - Multi write stores count words, max sixteen
// R8 - Diagnosis sub-function zero echoes query data
// R9 - Address is group high byte, index low
// R10 - Bad code or count gives exception, no write
module mrs_slave #(
  parameter int CLK_HZ = 250_000_000,
  parameter logic [7:0] SLAVE_ID = 8'h01,
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rxd,
  input wire logic [1:0] serialBitRateSetting,
  output logic txd,
  output logic txOe,
  output logic wrStrobe,
  output logic [15:0] wrAddr,
  output logic [15:0] wrData
);
  import mrs_pkg::*;

  // Whole state of the block
  typedef struct packed {
    mrs_state_t fsm;
    logic sync1; // First synchroniser stage
    logic sync2; // Safe receive level
    logic rxOn; // Character in progress
    logic [DIV_W-1:0] rxCnt;
    logic [3:0] rxBit;
    logic [7:0] rxSh;
    logic [5:0] gap; // Idle bit periods
    logic [5:0] nByte;
    logic bad; // Framing fault or overlong frame
    logic [15:0] crc;
    logic [7:0] slv;
    logic [7:0] fn;
    logic [15:0] a; // Start address or sub-function
    logic [15:0] q; // Count or value
    logic [15:0][15:0] stage; // Pending multi-write words
    logic [7:0] exc;
    logic [4:0] cmtIdx;
    logic txOn;
    logic txOe;
    logic [DIV_W-1:0] txCnt;
    logic [3:0] txBit;
    logic [9:0] txSh;
    logic [6:0] txIdx;
    logic [6:0] txLen;
    logic [15:0] txCrc;
    logic wrStb;
    logic [15:0] wrAddr;
    logic [15:0] wrData;
  } mrs_regs_t;

  // Counter reload per rate: one less than the cycles per bit, since the
  // down counter spends one extra cycle at zero before it reloads
  localparam logic [DIV_W-1:0] DIV_2400 = DIV_W'(CLK_HZ / BAUD_2400 - 1);
  localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / BAUD_4800 - 1);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / BAUD_9600 - 1);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / BAUD_19200 - 1);

  mrs_regs_t stReg; // Registered state
  mrs_regs_t stNext; // Next state
  logic [DIV_W-1:0] bitFull; // Bit period less one, counter reload
  logic [15:0] rdData; // Table word for the answer
  logic [15:0] rdAddr;

  // One step of the reflected CRC per byte
  function automatic logic [15:0] crcUpd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // Table index from group in high byte and index in low byte
  function automatic logic [AW-1:0] memIdx(input logic [15:0] ad);
    return {ad[8+AW/2-1:8], ad[AW/2-1:0]}; // R9
  endfunction

  // Rate select to bit period
  always_comb begin
    case (serialBitRateSetting)
      2'h0: bitFull = DIV_2400; // R6
      2'h1: bitFull = DIV_4800;
      2'h2: bitFull = DIV_9600;
      default: bitFull = DIV_19200;
    endcase
  end

  // Read address walks the word run upward from the start
  assign rdAddr = stReg.a + {9'h000, 7'(stReg.txIdx - RD_DATA_START) >> 1}; // R2 R3

  mrs_param_mem #(.AW(AW), .DW(16)) uMem (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .we(stReg.wrStb),
    .wAddr(memIdx(stReg.wrAddr)),
    .wData(stReg.wrData),
    .rAddr(memIdx(rdAddr)),
    .rData(rdData)
  );

  // Next-state logic for receive, check, commit and answer
  always_comb begin
    logic qOk;
    logic lenOk;
    logic [7:0] excCode;
    logic [7:0] txByte;
    logic [5:0] k;
    stNext = stReg;
    qOk = (stReg.q != 16'h0000) && (stReg.q <= MAX_WORDS);
    lenOk = 1'b0;
    excCode = 8'h00;
    txByte = 8'h00;
    k = stReg.nByte - DATA_START;
    stNext.wrStb = 1'b0;
    stNext.sync1 = rxd;
    stNext.sync2 = stReg.sync1;
    case (stReg.fsm)
      S_IDLE: begin
        if (!stReg.rxOn) begin
          // Wait for start bit, else time the silence
          if (!stReg.sync2) begin
            stNext.rxOn = 1'b1;
            stNext.rxCnt = bitFull >> 1;
            stNext.rxBit = 4'h0;
          end else if (stReg.rxCnt == '0) begin
            stNext.rxCnt = bitFull;
            if (stReg.gap != GAP_BITS) begin
              stNext.gap = stReg.gap + 6'h01;
            end else if (stReg.nByte != 6'h00) begin
              stNext.fsm = S_CHECK;
            end
          end else begin
            stNext.rxCnt = stReg.rxCnt - 1'b1;
          end
        end else if (stReg.rxCnt != '0) begin
          stNext.rxCnt = stReg.rxCnt - 1'b1;
        end else begin
          // Mid-bit sample
          stNext.rxCnt = bitFull; // R6
          stNext.rxBit = stReg.rxBit + 4'h1;
          if (stReg.rxBit == 4'h0 && stReg.sync2) begin
            stNext.rxOn = 1'b0; // Glitch, not a start bit
          end else if (stReg.rxBit != STOP_BIT) begin
            stNext.rxSh = {stReg.sync2, stReg.rxSh[7:1]};
          end else begin
            stNext.rxOn = 1'b0;
            stNext.gap = 6'h00;
            if (!stReg.sync2) begin
              stNext.bad = 1'b1;
            end else begin
              // Raw binary byte into the frame
              stNext.crc = crcUpd(stReg.crc, stReg.rxSh); // R4
              if (stReg.nByte == LEN_MAX) begin
                stNext.bad = 1'b1;
              end else begin
                stNext.nByte = stReg.nByte + 6'h01;
              end
              case (stReg.nByte)
                6'h00: stNext.slv = stReg.rxSh;
                6'h01: stNext.fn = stReg.rxSh;
                6'h02: stNext.a[15:8] = stReg.rxSh;
                6'h03: stNext.a[7:0] = stReg.rxSh;
                6'h04: stNext.q[15:8] = stReg.rxSh;
                6'h05: stNext.q[7:0] = stReg.rxSh;
                default: ;
              endcase
              // Multi-write data, high byte first
              if (stReg.fn == FN_WRITEN && stReg.nByte >= DATA_START && !k[5]) begin
                if (k[0]) begin
                  stNext.stage[k[4:1]][7:0] = stReg.rxSh; // R4
                end else begin
                  stNext.stage[k[4:1]][15:8] = stReg.rxSh;
                end
              end
            end
          end
        end
      end
      S_CHECK: begin
        // Length by command, exception by code and count
        if (stReg.fn == FN_WRITEN) begin
          lenOk = !qOk || stReg.nByte == 6'(LEN_MULTI_BASE + {stReg.q[4:0], 1'b0});
        end else begin
          lenOk = stReg.nByte == LEN_FIXED;
        end
        if (!(stReg.fn inside {FN_READ, FN_WRITE1, FN_DIAG, FN_WRITEN}) ||
            (stReg.fn == FN_DIAG && stReg.a != 16'h0000)) begin
          excCode = EXC_FUNC; // R10
        end else if ((stReg.fn == FN_READ || stReg.fn == FN_WRITEN) && !qOk) begin
          excCode = EXC_VALUE; // R10
        end
        stNext.nByte = 6'h00;
        stNext.crc = CRC_INIT;
        stNext.bad = 1'b0;
        stNext.fsm = S_IDLE;
        if (!stReg.bad && stReg.crc == 16'h0000 && lenOk &&
            (stReg.slv == SLAVE_ID || stReg.slv == 8'h00)) begin
          stNext.exc = excCode;
          stNext.cmtIdx = 5'h00;
          stNext.txIdx = 7'h00;
          stNext.txCrc = CRC_INIT;
          if (excCode != 8'h00) begin
            stNext.txLen = TX_LEN_EXC;
          end else if (stReg.fn == FN_READ) begin
            stNext.txLen = 7'(TX_LEN_READ_BASE + {stReg.q[4:0], 1'b0}); // R2
          end else begin
            stNext.txLen = TX_LEN_FIXED; // R8
          end
          if (excCode == 8'h00 && (stReg.fn == FN_WRITE1 || stReg.fn == FN_WRITEN)) begin
            stNext.fsm = S_COMMIT;
          end else if (stReg.slv != 8'h00) begin
            stNext.fsm = S_TX;
            stNext.txOe = 1'b1; // R1
          end
        end
      end
      S_COMMIT: begin
        // One word per cycle; single write stops after the first
        stNext.wrStb = 1'b1;
        stNext.wrAddr = stReg.a + {11'h000, stReg.cmtIdx}; // R7
        stNext.wrData = (stReg.fn == FN_WRITE1) ? stReg.q : stReg.stage[stReg.cmtIdx[3:0]];
        stNext.cmtIdx = stReg.cmtIdx + 5'h01;
        if (stReg.fn == FN_WRITE1 || 5'(stReg.cmtIdx + 5'h01) == stReg.q[4:0]) begin // R5 R7
          stNext.fsm = (stReg.slv == 8'h00) ? S_IDLE : S_TX;
          stNext.txOe = stReg.slv != 8'h00;
        end
      end
      default: begin
        // Answer byte by index; CRC closes it low byte first
        if (stReg.txIdx == 7'(stReg.txLen - 7'h02)) begin
          txByte = stReg.txCrc[7:0];
        end else if (stReg.txIdx == 7'(stReg.txLen - 7'h01)) begin
          txByte = stReg.txCrc[15:8];
        end else if (stReg.txIdx == 7'h00) begin
          txByte = stReg.slv;
        end else if (stReg.txIdx == 7'h01) begin
          txByte = (stReg.exc != 8'h00) ? (stReg.fn | EXC_FLAG) : stReg.fn;
        end else if (stReg.exc != 8'h00) begin
          txByte = stReg.exc;
        end else if (stReg.fn == FN_READ) begin
          if (stReg.txIdx == 7'h02) begin
            txByte = {stReg.q[6:0], 1'b0};
          end else begin
            txByte = stReg.txIdx[0] ? rdData[15:8] : rdData[7:0]; // R2 R4
          end
        end else begin
          // Echo of address and value or count, or of diagnosis data
          case (stReg.txIdx)
            7'h02: txByte = stReg.a[15:8]; // R8
            7'h03: txByte = stReg.a[7:0];
            7'h04: txByte = stReg.q[15:8];
            default: txByte = stReg.q[7:0];
          endcase
        end
        if (!stReg.txOn) begin
          if (stReg.txIdx == stReg.txLen) begin
            stNext.fsm = S_IDLE;
            stNext.txOe = 1'b0; // R1
            stNext.gap = 6'h00;
          end else begin
            if (stReg.txIdx < 7'(stReg.txLen - 7'h02)) begin
              stNext.txCrc = crcUpd(stReg.txCrc, txByte);
            end
            stNext.txSh = {1'b1, txByte, 1'b0};
            stNext.txBit = 4'h0;
            stNext.txCnt = bitFull; // R6
            stNext.txOn = 1'b1;
            stNext.txIdx = stReg.txIdx + 7'h01;
          end
        end else if (stReg.txCnt != '0) begin
          stNext.txCnt = stReg.txCnt - 1'b1;
        end else begin
          // Next bit slot; stop bit runs a full period
          stNext.txCnt = bitFull;
          if (stReg.txBit == STOP_BIT) begin
            stNext.txOn = 1'b0;
          end else begin
            stNext.txSh = {1'b1, stReg.txSh[9:1]};
            stNext.txBit = stReg.txBit + 4'h1;
          end
        end
      end
    endcase
  end

  // State register; idle line levels are high
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stReg <= '0;
      stReg.sync1 <= 1'b1;
      stReg.sync2 <= 1'b1;
      stReg.txSh <= '1;
      stReg.crc <= CRC_INIT;
    end else begin
      stReg <= stNext;
    end
  end

  assign txd = stReg.txSh[0];
  assign txOe = stReg.txOe;
  assign wrStrobe = stReg.wrStb;
  assign wrAddr = stReg.wrAddr;
  assign wrData = stReg.wrData;

  // Checks on the frame engine
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_no_drive_rx: assert property (stReg.rxOn |-> !txOe) // R1
    else $error("driver on while receiving");
  a_drive_after_check: assert property ($rose(txOe) |-> $past(stReg.fsm) != S_IDLE) // R1
    else $error("driver enabled from idle");
  a_read_length: assert property (($past(stReg.fsm) == S_CHECK && stReg.fsm == S_TX &&
      stReg.fn == FN_READ && stReg.exc == 8'h00) |-> stReg.txLen == 7'(5 + 2 * stReg.q)) // R2
    else $error("read answer length wrong");
  a_stop_high: assert property ((stReg.txOn && stReg.txBit == STOP_BIT) |-> txd) // R4
    else $error("stop bit not high");
  a_single_write: assert property ((wrStrobe && stReg.fn == FN_WRITE1) |=> !wrStrobe) // R5
    else $error("single write repeated");
  a_bit_load: assert property ($rose(stReg.txOn) |-> stReg.txCnt == bitFull && !txd) // R6
    else $error("bit period not from setting");
  a_multi_count: assert property (($past(stReg.fsm) == S_COMMIT && stReg.fsm != S_COMMIT &&
      stReg.fn == FN_WRITEN) |-> stReg.cmtIdx == stReg.q[4:0]) // R7
    else $error("multi write count wrong");
  a_echo_length: assert property ((stReg.fsm == S_TX && stReg.fn == FN_DIAG &&
      stReg.exc == 8'h00) |-> stReg.txLen == TX_LEN_FIXED) // R8
    else $error("echo length wrong");
  a_exc_no_write: assert property (stReg.fsm == S_COMMIT |-> stReg.exc == 8'h00) // R10
    else $error("write despite exception");
  a_exc_length: assert property ((stReg.fsm == S_TX && stReg.exc != 8'h00) |->
      stReg.txLen == TX_LEN_EXC) // R10
    else $error("exception length wrong");

  c_read_answer: cover property (stReg.fsm == S_TX && stReg.fn == FN_READ && stReg.exc == 8'h00);
  c_multi_write: cover property (wrStrobe && stReg.fn == FN_WRITEN);
  c_exception: cover property (stReg.fsm == S_TX && stReg.exc != 8'h00);
  c_echo: cover property (stReg.fsm == S_TX && stReg.fn == FN_DIAG);
endmodule // mrs_slave
